/* src/slg_defines.vh */
// constants for the strap latch and general output block
`ifndef SLG_DEFINES_VH
`define SLG_DEFINES_VH
`define SLG_CLK_HZ        10000000
`define SLG_OFF_CTRL      12'h000
`define SLG_OFF_GPO       12'h004
`define SLG_OFF_STRAP     12'h008
`define SLG_OFF_STATUS    12'h00C
`define SLG_OFF_MASK      12'h010
`define SLG_OFF_IRQSET    12'h014
`define SLG_CTRL_RST      32'h00000000
`define SLG_GPO_RST       32'h00000000
`define SLG_MASK_RST      32'h00000000
`define SLG_CTRL_MDIX_OVR 0
`define SLG_CTRL_MDIX_VAL 1
`define SLG_CTRL_INTSEL   2
`define SLG_ST_LATCHED    0
`define SLG_ST_GPI        1
`define SLG_ST_SOFT       2
`define SLG_ST_W          3
`endif

/* src/slg_sync_edge.v */
// two-stage synchroniser with rising edge pulse
`timescale 1ns/100ps
`include "slg_defines.vh"
module slg_sync_edge (
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output wire level,
  output wire rise
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
endmodule

/* src/slg_sticky.v */
// sticky status bit, set wins over write-one clear
`timescale 1ns/100ps
`include "slg_defines.vh"
module slg_sticky (
  input  wire clk,
  input  wire rst_n,
  input  wire set,
  input  wire clr,
  output reg  flag_q
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule

/* src/slg_top.v */
// strap capture, general outputs and shared interrupt pin
// What this block does
// - latch all straps when reset releases
// - crossover strap high selects crossed pairing
// - crossover strap used when auto disabled
// - interface strap: low mii, high rmii
// - general outputs driven from control bits
// - output 1 shares address bit 4 pin
// - interrupt low, shares transmit error pin
// - mode bits loaded from mode straps
// - five address straps set default address
// - auto crossover strap, register override
// - three mode straps set default mode
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "slg_defines.vh"
module slg_top #(
  parameter ADDR_W = 5,
  parameter MODE_W = 3
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              ext_reset_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              crossover_select_strap,
  input  wire              auto_crossover_enable_strap,
  input  wire [MODE_W-1:0] mode_strap,
  input  wire [3:0]        addr_strap_low,
  input  wire              addr_strap_bit4_in,
  output wire              general_output_1,
  output wire              general_output_1_oe,
  input  wire              rmii_strap_in,
  output wire              general_output_0,
  output wire              general_output_0_oe,
  output wire              general_output_2,
  input  wire              intsel_strap_in,
  input  wire              tx_error_in,
  output wire              irq_out_n,
  output wire              irq_out_n_oe,
  input  wire              int_event,
  output reg  [ADDR_W-1:0] phy_address_q,
  output reg  [MODE_W-1:0] op_mode_q,
  output reg               rmii_mode_q,
  output reg               intsel_q,
  output wire              auto_crossover_on,
  output wire              crossed_pairing,
  output wire              tx_error_out,
  output wire              irq
);
  reg  [2:0]  gpo_q;
  reg  [2:0]  ctrl_q;
  reg  [3:0]  mask_q;
  reg         run_q;
  reg         mdix_strap_q;
  reg         chsel_strap_q;
  reg  [3:0]  soft_ev_q;
  wire        ext_lvl;
  wire        ext_rise;
  wire        int_lvl;
  wire        int_rise;
  wire [3:0]  status;
  wire [3:0]  ev_set;
  wire [3:0]  ev_clr;
  wire        wr_en;
  wire        wr_irqset;

  slg_sync_edge u_rst_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (ext_reset_n),
    .level (ext_lvl),
    .rise  (ext_rise)
  );

  slg_sync_edge u_int_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (int_event),
    .level (int_lvl),
    .rise  (int_rise)
  );

  // strap capture on release of external reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q         <= 1'b0;
      phy_address_q <= {ADDR_W{1'b0}};
      op_mode_q     <= {MODE_W{1'b0}};
      rmii_mode_q   <= 1'b0;
      intsel_q      <= 1'b0;
      mdix_strap_q  <= 1'b1;
      chsel_strap_q <= 1'b1;
    end else if (!ext_lvl) begin
      run_q <= 1'b0;
    end else if (ext_rise) begin
      run_q         <= 1'b1;
      phy_address_q <= {addr_strap_bit4_in, addr_strap_low};
      op_mode_q     <= mode_strap;
      rmii_mode_q   <= rmii_strap_in;
      intsel_q      <= intsel_strap_in;
      mdix_strap_q  <= auto_crossover_enable_strap;
      chsel_strap_q <= crossover_select_strap;
    end
  end

  // register override of the auto crossover strap
  assign auto_crossover_on = ctrl_q[`SLG_CTRL_MDIX_OVR] ? ctrl_q[`SLG_CTRL_MDIX_VAL]
                                                        : mdix_strap_q;
  // manual channel choice only when auto crossover is off; auto picks crossed by default
  assign crossed_pairing = auto_crossover_on ? 1'b1 : chsel_strap_q;

  // shared pins released while external reset holds
  assign general_output_0    = gpo_q[0];
  assign general_output_1    = gpo_q[1];
  assign general_output_2    = run_q ? gpo_q[2] : 1'b0;
  assign general_output_0_oe = run_q;
  assign general_output_1_oe = run_q;

  // shared interrupt / transmit error pin, open drain when used as interrupt
  assign irq_out_n    = 1'b0;
  assign irq_out_n_oe = run_q & intsel_q & irq;
  assign tx_error_out = intsel_q ? 1'b0 : tx_error_in;

  // interrupt status: strap latched, general event, software test
  assign wr_en     = psel & penable & pwrite;
  assign wr_irqset = wr_en && (paddr == `SLG_OFF_IRQSET);
  assign ev_set[`SLG_ST_LATCHED] = ext_rise;
  assign ev_set[`SLG_ST_GPI]     = int_rise & int_lvl;
  assign ev_set[`SLG_ST_SOFT]    = soft_ev_q[`SLG_ST_SOFT];
  assign ev_set[3]               = soft_ev_q[3];
  assign ev_clr = (wr_en && (paddr == `SLG_OFF_STATUS)) ? pwdata[3:0] : 4'h0;

  genvar gi;
  generate
    for (gi = 0; gi < `SLG_ST_W; gi = gi + 1) begin : g_st
      slg_sticky u_st (
        .clk    (pclk),
        .rst_n  (presetn),
        .set    (ev_set[gi]),
        .clr    (ev_clr[gi]),
        .flag_q (status[gi])
      );
    end
  endgenerate
  assign status[3] = 1'b0;

  assign irq = |(status & mask_q);

  // apb registers
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= 3'h0;
      gpo_q     <= 3'h0;
      mask_q    <= 4'h0;
      soft_ev_q <= 4'h0;
    end else begin
      soft_ev_q <= 4'h0;
      if (wr_en) begin
        if (paddr == `SLG_OFF_CTRL) begin
          ctrl_q <= pwdata[2:0];
        end else if (paddr == `SLG_OFF_GPO) begin
          gpo_q <= pwdata[2:0];
        end else if (paddr == `SLG_OFF_MASK) begin
          mask_q <= {1'b0, pwdata[2:0]};
        end else if (wr_irqset) begin
          soft_ev_q <= {1'b0, pwdata[`SLG_ST_SOFT], 2'h0};
        end
      end
    end
  end

  always @* begin
    prdata = 32'h00000000;
    if (paddr == `SLG_OFF_CTRL) begin
      prdata[2:0] = ctrl_q;
    end else if (paddr == `SLG_OFF_GPO) begin
      prdata[2:0] = gpo_q;
    end else if (paddr == `SLG_OFF_STRAP) begin
      prdata[4:0]   = phy_address_q;
      prdata[10:8]  = op_mode_q;
      prdata[12]    = rmii_mode_q;
      prdata[13]    = intsel_q;
      prdata[14]    = chsel_strap_q;
      prdata[15]    = mdix_strap_q;
      prdata[16]    = auto_crossover_on;
      prdata[17]    = crossed_pairing;
      prdata[18]    = run_q;
    end else if (paddr == `SLG_OFF_STATUS) begin
      prdata[3:0] = status;
    end else if (paddr == `SLG_OFF_MASK) begin
      prdata[3:0] = mask_q;
    end
  end
endmodule

/* tb/slg_top_monitor.sv */
// checker for strap latch, shared pins and interrupt pin
`timescale 1ns/100ps
module slg_chk #(parameter ADDR_W = 5) (
  input logic              pclk,
  input logic              presetn,
  input logic              ext_reset_n,
  input logic [3:0]        addr_strap_low,
  input logic [ADDR_W-1:0] phy_address_q,
  input logic              general_output_0_oe,
  input logic              general_output_1_oe,
  input logic              general_output_2,
  input logic              intsel_q,
  input logic              irq,
  input logic              irq_out_n_oe,
  input logic              tx_error_in,
  input logic              tx_error_out,
  input logic              auto_crossover_on,
  input logic              crossed_pairing
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_held; !ext_reset_n [*4]; endsequence
  sequence s_release; $rose(ext_reset_n); endsequence
  chk_oe_reset: assert property (s_held |-> !general_output_0_oe && !general_output_1_oe)
    else $error("shared pin driven in reset");
  chk_addr_latch: assert property (s_release |-> ##[2:4]
    (general_output_0_oe && phy_address_q[3:0] == addr_strap_low)) else $error("latch late");
  chk_run_hold: assert property (general_output_1_oe && ext_reset_n |=> general_output_1_oe)
    else $error("run lost");
  chk_oe_pair: assert property (general_output_0_oe == general_output_1_oe)
    else $error("enables differ");
  chk_gpo_idle: assert property (!general_output_0_oe |-> !general_output_2)
    else $error("output 2 high idle");
  chk_irq_pin: assert property (irq_out_n_oe == (general_output_0_oe && intsel_q && irq))
    else $error("irq pin wrong");
  chk_txer_mux: assert property (tx_error_out == (!intsel_q && tx_error_in))
    else $error("tx error mux wrong");
  chk_cross_auto: assert property (auto_crossover_on |-> crossed_pairing)
    else $error("pairing wrong");
endmodule
bind slg_top slg_chk #(.ADDR_W(ADDR_W)) slg_chk_i (.pclk, .presetn, .ext_reset_n,
  .addr_strap_low, .phy_address_q, .general_output_0_oe, .general_output_1_oe,
  .general_output_2, .intsel_q, .irq, .irq_out_n_oe, .tx_error_in, .tx_error_out,
  .auto_crossover_on, .crossed_pairing);

/* tb/slg_board.sv */
// board strap pulls and shared pin levels
`timescale 1ns/100ps
module slg_board (
  input  wire [11:0] cfg,
  input  wire        g0,
  input  wire        g0_oe,
  input  wire        g1,
  input  wire        g1_oe,
  output wire [11:0] pin
);
  // a pull shows its level until the device drives the shared pin
  assign pin = {cfg[11:9], g0_oe ? g0 : cfg[8], cfg[7:5], g1_oe ? g1 : cfg[4], cfg[3:0]};
endmodule

/* tb/slg_top_tb_top.sv */
// self-checking bench for strap latch and general outputs
`timescale 1ns/100ps
`include "slg_defines.vh"
module slg_top_tb_top;
  reg         pclk = 0, presetn = 0, ext_reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  reg         tx_error_in = 1, int_event = 0;
  reg  [11:0] paddr = 12'h000, cfg = 12'h000;
  reg  [31:0] pwdata = 32'h00000000, rdat;
  integer     mismatches = 0, comparisons = 0, cycles = 0;
  wire [31:0] prdata;
  wire [11:0] pin;
  wire        pready, g0, g0_oe, g1, g1_oe, g2, irq_n, irq_oe, irq, ao, cr, txo;
  slg_board slg_board_i (.cfg(cfg), .g0(g0), .g0_oe(g0_oe), .g1(g1), .g1_oe(g1_oe), .pin(pin));
  slg_top slg_top_i (.pclk(pclk), .presetn(presetn), .ext_reset_n(ext_reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .crossover_select_strap(pin[10]),
    .auto_crossover_enable_strap(pin[11]), .mode_strap(pin[7:5]), .addr_strap_low(pin[3:0]),
    .addr_strap_bit4_in(pin[4]), .general_output_1(g1), .general_output_1_oe(g1_oe),
    .rmii_strap_in(pin[8]), .general_output_0(g0), .general_output_0_oe(g0_oe),
    .general_output_2(g2), .intsel_strap_in(pin[9]), .tx_error_in(tx_error_in),
    .irq_out_n(irq_n), .irq_out_n_oe(irq_oe), .int_event(int_event), .phy_address_q(),
    .op_mode_q(), .rmii_mode_q(), .intsel_q(), .auto_crossover_on(ao),
    .crossed_pairing(cr), .tx_error_out(txo), .irq(irq));
  always #50 pclk = ~pclk;
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h00000000);
      cmp(rdat, e);
    end
  endtask
  task boot(input [11:0] c);
    begin
      cfg <= c;
      ext_reset_n <= 1'b0;
      repeat (4) @(posedge pclk);
      cmp({g0_oe, g1_oe}, 2'b00);
      ext_reset_n <= 1'b1;
      while (g0_oe !== 1'b1) @(negedge pclk);
      @(posedge pclk);
    end
  endtask
  function [31:0] sx(input [11:0] c, input a);
    sx = {13'h0000, 1'b1, a | c[10], a, c[11:8], 1'b0, c[7:5], 3'h0, c[4:0]};
  endfunction
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`SLG_OFF_CTRL, `SLG_CTRL_RST);
    rdc(`SLG_OFF_GPO, `SLG_GPO_RST);
    rdc(`SLG_OFF_MASK, `SLG_MASK_RST);
    rdc(12'h020, 32'h00000000);
    boot(12'hC4A);
    rdc(`SLG_OFF_STRAP, sx(12'hC4A, 1'b1));
    cmp(txo, 1'b1);
    cfg <= 12'h3B5;
    rdc(`SLG_OFF_STRAP, sx(12'hC4A, 1'b1));
    boot(12'h3B5);
    rdc(`SLG_OFF_STRAP, sx(12'h3B5, 1'b0));
    cmp(txo, 1'b0);
    apb(1'b1, `SLG_OFF_CTRL, 32'h00000003);
    rdc(`SLG_OFF_STRAP, sx(12'h3B5, 1'b1));
    apb(1'b1, `SLG_OFF_CTRL, 32'h00000001);
    cmp({ao, cr}, 2'b00);
    apb(1'b1, `SLG_OFF_GPO, 32'h00000007);
    cmp({g2, g1, g0, pin[4]}, 4'hF);
    apb(1'b1, `SLG_OFF_GPO, 32'h00000002);
    cmp({g2, g1, g0, pin[8]}, 4'h4);
    rdc(`SLG_OFF_STATUS, 32'h00000001);
    apb(1'b1, `SLG_OFF_MASK, 32'h00000002);
    int_event <= 1'b1;
    while (irq !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    cmp({irq_oe, irq_n}, 2'b10);
    int_event <= 1'b0;
    apb(1'b1, `SLG_OFF_STATUS, 32'h00000002);
    rdc(`SLG_OFF_STATUS, 32'h00000001);
    apb(1'b1, `SLG_OFF_IRQSET, 32'h00000004);
    rdc(`SLG_OFF_STATUS, 32'h00000005);
    cmp(irq, 1'b0);
    apb(1'b1, `SLG_OFF_MASK, 32'h00000004);
    cmp(irq, 1'b1);
    apb(1'b1, `SLG_OFF_STATUS, 32'h00000007);
    cmp({irq, irq_oe}, 2'b00);
    stop_test;
  end
endmodule
